// ===== src/can_cmd_pkg.sv
package can_cmd_pkg;
    // Frame identifier layout
    localparam logic [10:0] SYNC_PATTERN = 11'h555;
    localparam int          CMD_LSB      = 5;
    localparam int          ADDR_BITS    = 5;
    // Command codes
    localparam logic [5:0] CMD_SEQ_WRITE   = 6'h00;
    localparam logic [5:0] CMD_SEL_WRITE   = 6'h01;
    localparam logic [5:0] CMD_FB_EXIT     = 6'h03;
    localparam logic [5:0] CMD_START       = 6'h04;
    localparam logic [5:0] CMD_OFF         = 6'h05;
    localparam logic [5:0] CMD_FB_REFRESH  = 6'h06;
    localparam logic [5:0] CMD_TRIM_SEL    = 6'h07;
    localparam logic [5:0] CMD_DUTY_A      = 6'h08;
    localparam logic [5:0] CMD_DUTY_B      = 6'h09;
    localparam logic [5:0] CMD_DUTY_C      = 6'h0a;
    localparam logic [5:0] CMD_DUTY_PAIR   = 6'h0c;
    localparam logic [5:0] CMD_DIAG_TRIG   = 6'h0d;
    localparam logic [5:0] CMD_NVM_WRITE   = 6'h0e;
    localparam logic [5:0] CMD_SEQ_READ    = 6'h10;
    localparam logic [5:0] CMD_SEL_READ    = 6'h11;
    localparam logic [5:0] CMD_DIAG_READ   = 6'h12;
    localparam logic [5:0] CMD_FD_SEQ_READ = 6'h13;
    localparam logic [5:0] CMD_FD_SEL_READ = 6'h14;
    localparam logic [5:0] CMD_FEEDBACK    = 6'h15;
    localparam logic [5:0] CMD_BC_FIRST    = 6'h20;
    localparam logic [5:0] CMD_BC_TRIM     = 6'h22;
    localparam logic [5:0] CMD_BC_EXIT     = 6'h26;
    // Fallback exit field steps, bits 6:4 of each exit byte
    localparam logic [2:0] EXIT_STEP1 = 3'b001;
    localparam logic [2:0] EXIT_STEP2 = 3'b010;
    localparam logic [2:0] EXIT_STEP3 = 3'b100;
    // Register map and reset values
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_TRIM     = 8'h08;
    localparam logic [7:0] REG_COUNT    = 8'h0c;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;
endpackage

// ===== src/can_command_decoder.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Commands arrive with extended identifier only
// - Base identifier must be 10101010101
// - Decode command and five-bit device address
// - Retrim sampling clock on every sync frame
// - First payload byte is most significant
// - Consecutive write lengths, counts, fallback reject
// - Selective write lengths, counts, fallback reject
// - Selective fallback exit: three bytes, always
// - Start and off: two bytes, not fallback
// - Watchdog refresh: one byte, always valid
// - Direct duty writes: direct, classic, eight
// - Paired duty broadcast: direct, FD, fourteen
// - Memory write: four bytes, key, unlocked
// - Classic reads: one, or one to eight
// - FD reads: lengths and register counts
// - Feedback smart only; diagnosis always valid
// - Codes 2, 11, 15 are invalid
// - Fallback allows only fallback control writes
// - Broadcast 38 exits fallback for all
module can_command_decoder
    import can_cmd_pkg::*;
#(
    parameter int         ADDR_W  = 8,
    parameter logic [7:0] NVM_KEY = 8'ha5
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              frame_valid,
    input  wire logic              frame_ide,
    input  wire logic              frame_fd,
    input  wire logic [10:0]       frame_std_id,
    input  wire logic [17:0]       frame_ext_id,
    input  wire logic [3:0]        frame_len,
    input  wire logic [119:0]      frame_data,
    input  wire logic [15:0]       frame_sync_span,
    input  wire logic              fallback_enter,
    output logic                   exec_valid,
    output logic [5:0]             exec_cmd,
    output logic                   exec_broadcast,
    output logic [3:0]             exec_len,
    output logic [119:0]           exec_data,
    output logic                   reject_valid,
    output logic                   fallback_mode,
    output logic [15:0]            trim_code
);
    check_if chk_bus ();

    logic [7:0]   ctrl;
    logic         pend;
    logic [5:0]   cur_cmd;
    logic [4:0]   cur_addr;
    logic         cur_fd;
    logic [3:0]   cur_len;
    logic [119:0] cur_data;
    logic         sync_ok;
    logic         addressed;
    logic         accept_now;
    logic         exit_fields;
    logic         exit_fire;
    logic [15:0]  accept_count;
    logic [15:0]  reject_count;
    logic         aw_held;
    logic         w_held;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic [31:0]  next_rdata;

    // ****************************************************************
    // Frame intake and clock trimming
    // ****************************************************************

    // Only extended frames carrying the sync pattern are commands
    assign sync_ok = frame_valid && frame_ide && frame_std_id == SYNC_PATTERN;

    // Capture the header fields; reserved bits 17:11 are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend     <= 1'b0;
            cur_cmd  <= 6'h00;
            cur_addr <= 5'h00;
            cur_fd   <= 1'b0;
            cur_len  <= 4'h0;
            cur_data <= '0;
        end else begin
            pend <= sync_ok;
            if (sync_ok) begin
                cur_cmd  <= frame_ext_id[CMD_LSB+5:CMD_LSB];
                cur_addr <= frame_ext_id[ADDR_BITS-1:0];
                cur_fd   <= frame_fd;
                cur_len  <= frame_len;
                cur_data <= frame_data;
            end
        end
    end

    // Every synchronising frame retrims, whatever its address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_code <= 16'h0000;
        end else if (sync_ok) begin
            trim_code <= frame_sync_span;
        end
    end

    // ****************************************************************
    // Validation
    // ****************************************************************

    // Byte 0 sits in the top lane, so it is the most significant
    assign chk_bus.cmd             = cur_cmd;
    assign chk_bus.fd              = cur_fd;
    assign chk_bus.len             = cur_len;
    assign chk_bus.first_data_byte = cur_data[119:112];
    assign chk_bus.key             = cur_data[119:112];
    assign chk_bus.fallback_mode   = fallback_mode;
    assign chk_bus.direct_variant  = ctrl[5];
    assign chk_bus.nvm_locked      = ctrl[6];
    assign chk_bus.nvm_cfg         = ctrl[7];

    cmd_validator #(
        .NVM_KEY (NVM_KEY)
    ) u_validator (
        .chk (chk_bus)
    );

    // Broadcast codes and the paired duty write ignore the address
    assign addressed = cur_cmd >= CMD_BC_FIRST || cur_cmd == CMD_DUTY_PAIR || cur_addr == ctrl[4:0];
    assign accept_now = pend && addressed && chk_bus.ok;

    // Exit needs the three steps in bytes 0, 1, 2
    assign exit_fields = cur_data[118:116] == EXIT_STEP1 && cur_data[110:108] == EXIT_STEP2
                         && cur_data[102:100] == EXIT_STEP3;
    assign exit_fire = accept_now && exit_fields && (cur_cmd == CMD_FB_EXIT || cur_cmd == CMD_BC_EXIT);

    // ****************************************************************
    // Command issue and fallback state
    // ****************************************************************

    // Accepted frames are issued; other sync frames only pulse reject
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exec_valid     <= 1'b0;
            reject_valid   <= 1'b0;
            exec_cmd       <= 6'h00;
            exec_broadcast <= 1'b0;
            exec_len       <= 4'h0;
            exec_data      <= '0;
        end else begin
            exec_valid   <= accept_now;
            reject_valid <= pend && !accept_now;
            if (accept_now) begin
                exec_cmd       <= cur_cmd;
                exec_broadcast <= cur_cmd >= CMD_BC_FIRST || cur_cmd == CMD_DUTY_PAIR;
                exec_len       <= cur_len;
                exec_data      <= cur_data;
            end
        end
    end

    // Entry wins over a coincident exit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fallback_mode <= 1'b0;
        end else if (fallback_enter) begin
            fallback_mode <= 1'b1;
        end else if (exit_fire) begin
            fallback_mode <= 1'b0;
        end
    end

    // Frame statistics
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accept_count <= 16'h0000;
            reject_count <= 16'h0000;
        end else begin
            if (accept_now) begin
                accept_count <= accept_count + 16'h0001;
            end
            if (pend && !accept_now) begin
                reject_count <= reject_count + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Register bus slave
    // ****************************************************************

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data are held until both have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= 8'(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Control register: address, variant, lock, config mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
        end else if (aw_held && w_held && aw_addr == REG_CTRL && w_strb[0]) begin
            ctrl <= w_data[7:0];
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr <= REG_COUNT && aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (8'(s_axi_araddr))
            REG_CTRL:   next_rdata = {24'h000000, ctrl};
            REG_STATUS: next_rdata = {16'h0000, 2'b00, exec_cmd, 7'h00, fallback_mode};
            REG_TRIM:   next_rdata = {16'h0000, trim_code};
            REG_COUNT:  next_rdata = {reject_count, accept_count};
            default:    next_rdata = 32'h0000_0000;
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= (8'(s_axi_araddr) <= REG_COUNT && s_axi_araddr[1:0] == 2'b00)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    property p_sync_only;
        @(posedge aclk) disable iff (!aresetn)
        frame_valid && (!frame_ide || frame_std_id != SYNC_PATTERN) |=> !pend;
    endproperty
    a_sync_only: assert property (p_sync_only) else $error("non-sync frame taken");

    property p_trim;
        @(posedge aclk) disable iff (!aresetn)
        sync_ok |=> trim_code == $past(frame_sync_span);
    endproperty
    a_trim: assert property (p_trim) else $error("trim not updated");

    property p_cmd_field;
        @(posedge aclk) disable iff (!aresetn)
        sync_ok ##1 accept_now |=> exec_valid && exec_cmd == $past(frame_ext_id[10:5], 2);
    endproperty
    a_cmd_field: assert property (p_cmd_field) else $error("command field wrong");

    property p_msb_first;
        @(posedge aclk) disable iff (!aresetn)
        sync_ok ##1 accept_now |=> exec_data[119:112] == $past(frame_data[119:112], 2);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("byte order wrong");

    property p_no_write_fb;
        @(posedge aclk) disable iff (!aresetn)
        pend && fallback_mode && (cur_cmd == CMD_SEQ_WRITE || cur_cmd == CMD_SEL_WRITE) |=> reject_valid;
    endproperty
    a_no_write_fb: assert property (p_no_write_fb) else $error("write in fallback");

    property p_wrong_addr;
        @(posedge aclk) disable iff (!aresetn)
        pend && cur_cmd < CMD_DUTY_PAIR && cur_addr != ctrl[4:0] |=> !exec_valid && reject_valid;
    endproperty
    a_wrong_addr: assert property (p_wrong_addr) else $error("foreign frame issued");

    property p_undefined;
        @(posedge aclk) disable iff (!aresetn)
        pend && (cur_cmd == 6'h02 || cur_cmd == 6'h0b || cur_cmd == 6'h0f) |=> reject_valid;
    endproperty
    a_undefined: assert property (p_undefined) else $error("undefined code issued");

    property p_duty;
        @(posedge aclk) disable iff (!aresetn)
        exec_valid && exec_cmd >= CMD_DUTY_A && exec_cmd <= CMD_DUTY_C |-> exec_len == 4'd8 && $past(ctrl[5]);
    endproperty
    a_duty: assert property (p_duty) else $error("duty write bad");

    property p_refresh;
        @(posedge aclk) disable iff (!aresetn)
        pend && cur_cmd == CMD_FB_REFRESH && cur_len == 4'd1 && addressed |=> exec_valid;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh dropped");

    property p_bc_exit;
        @(posedge aclk) disable iff (!aresetn)
        pend && cur_cmd == CMD_BC_EXIT && cur_len == 4'd3 && exit_fields && !fallback_enter |=> !fallback_mode;
    endproperty
    a_bc_exit: assert property (p_bc_exit) else $error("broadcast exit ignored");
endmodule
`default_nettype wire

// ===== src/check_if.sv
`timescale 1ns/1ps
`default_nettype none
interface check_if;
    logic [5:0] cmd;
    logic       fd;
    logic [3:0] len;
    logic [7:0] first_data_byte;
    logic [7:0] key;
    logic       fallback_mode;
    logic       direct_variant;
    logic       nvm_locked;
    logic       nvm_cfg;
    logic       ok;
    modport top (output cmd, fd, len, first_data_byte, key, fallback_mode,
                 output direct_variant, nvm_locked, nvm_cfg, input ok);
    modport chk (input cmd, fd, len, first_data_byte, key, fallback_mode,
                 input direct_variant, nvm_locked, nvm_cfg, output ok);
endinterface
`default_nettype wire

// ===== src/cmd_validator.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_validator
    import can_cmd_pkg::*;
#(
    parameter logic [7:0] NVM_KEY = 8'ha5
) (
    check_if.chk chk
);
    logic [8:0] len9;
    logic [8:0] pairs_len;
    logic [8:0] count_len;
    logic       fb;
    logic       no_regs;

    // Length arithmetic for count-carrying frames
    assign len9      = {5'h00, chk.len};
    assign pairs_len = {chk.first_data_byte, 1'b1};
    assign count_len = {1'b0, chk.first_data_byte};
    assign fb        = chk.fallback_mode;
    assign no_regs   = (chk.first_data_byte == 8'h00);

    // Per-command length, link, variant and condition table
    always_comb begin
        chk.ok = 1'b0;
        case (chk.cmd)
            CMD_SEQ_WRITE: begin
                if (chk.fd) begin
                    chk.ok = !fb && chk.len >= 4'd3 && !no_regs && len9 == count_len + 9'd2;
                end else begin
                    chk.ok = !fb && chk.len >= 4'd2 && chk.len <= 4'd8;
                end
            end
            CMD_SEL_WRITE: begin
                if (chk.fd) begin
                    chk.ok = !fb && chk.len >= 4'd3 && !no_regs && len9 == pairs_len;
                end else begin
                    chk.ok = !fb && chk.len >= 4'd2 && chk.len <= 4'd8 && !chk.len[0];
                end
            end
            CMD_FB_EXIT, CMD_BC_EXIT: chk.ok = (chk.len == 4'd3);
            CMD_START, CMD_OFF:       chk.ok = !fb && chk.len == 4'd2;
            CMD_FB_REFRESH:           chk.ok = (chk.len == 4'd1);
            CMD_TRIM_SEL, CMD_BC_TRIM, CMD_DIAG_TRIG, CMD_DIAG_READ: begin
                chk.ok = (chk.len == 4'd0);
            end
            CMD_DUTY_A, CMD_DUTY_B, CMD_DUTY_C: begin
                chk.ok = chk.direct_variant && !chk.fd && chk.len == 4'd8 && !fb;
            end
            CMD_DUTY_PAIR: chk.ok = chk.direct_variant && chk.fd && chk.len == 4'd14 && !fb;
            CMD_NVM_WRITE: begin
                chk.ok = chk.len == 4'd4 && !fb && !chk.nvm_locked && chk.nvm_cfg && chk.key == NVM_KEY;
            end
            CMD_SEQ_READ:    chk.ok = !chk.fd && chk.len == 4'd1;
            CMD_SEL_READ:    chk.ok = !chk.fd && chk.len >= 4'd1 && chk.len <= 4'd8;
            CMD_FD_SEQ_READ: chk.ok = chk.fd && chk.len == 4'd2 && !no_regs;
            CMD_FD_SEL_READ: chk.ok = chk.fd && chk.len >= 4'd2 && !no_regs && len9 == count_len + 9'd1;
            CMD_FEEDBACK:    chk.ok = !chk.direct_variant && chk.len == 4'd0;
            default:         chk.ok = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== test/can_command_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module can_command_decoder_bench;
    import can_cmd_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_valid, frame_ide, frame_fd;
    logic fallback_enter, exec_valid, exec_broadcast, reject_valid, fallback_mode;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb, frame_len, exec_len;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [10:0] frame_std_id;
    logic [17:0] frame_ext_id;
    logic [119:0] frame_data, exec_data;
    logic [15:0] frame_sync_span, trim_code;
    logic [5:0] exec_cmd;
    int cmp_count, n_mismatch, cyc;
    can_command_decoder dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_valid,
        .frame_ide, .frame_fd, .frame_std_id, .frame_ext_id, .frame_len, .frame_data, .frame_sync_span,
        .fallback_enter, .exec_valid, .exec_cmd, .exec_broadcast, .exec_len, .exec_data, .reject_valid,
        .fallback_mode, .trim_code);
    host_frame_model host (.aclk, .frame_valid, .frame_ide, .frame_fd, .frame_std_id, .frame_ext_id,
        .frame_len, .frame_data, .frame_sync_span);
    // ****************************************
    // Clock, timeout and verdict
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // Register bus master
    // ****************************************
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int t = 0; t < 50 && !(aw && w && s_axi_bvalid); t++) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
            if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        ar = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int t = 0; t < 50 && !(ar && s_axi_rvalid); t++) begin
            @(posedge aclk);
            if (!ar && s_axi_arready) begin ar = 1; s_axi_arvalid <= 1'b0; end
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Frame with outcome check one edge after the take
    task automatic frm(input logic fd, input logic [5:0] c, input logic [4:0] a, input logic [3:0] l,
                       input logic [23:0] b, input logic ok);
        host.send(fd, c, a, l, b, SYNC_PATTERN);
        @(posedge aclk);
        #1;
        `CHK(exec_valid, ok)
        `CHK(reject_valid, !ok)
        `CHK(trim_code, 16'h0140 + {10'h000, c})
        if (ok) `CHK({exec_cmd, exec_len, exec_data[119:96]}, {c, l, b})
        if (ok) `CHK(exec_broadcast, c == CMD_DUTY_PAIR || c >= CMD_BC_FIRST)
    endtask
    task automatic fb_enter();
        @(posedge aclk);
        fallback_enter <= 1'b1;
        @(posedge aclk);
        fallback_enter <= 1'b0;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fallback_enter} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(REG_CTRL, rd_data, resp);
        `CHK({rd_data, resp}, {32'h00000000, RESP_OKAY})
        axi_rd(8'h10, rd_data, resp);
        `CHK({rd_data, resp}, {32'h00000000, RESP_SLVERR})
        axi_wr(REG_CTRL, 32'h000000a5, resp);
        `CHK(resp, RESP_OKAY)
        axi_rd(REG_CTRL, rd_data, resp);
        `CHK({rd_data, resp}, {32'h000000a5, RESP_OKAY})
        $display("test done: registers");
        host.send(1'b0, CMD_DIAG_READ, 5'h05, 4'h0, 24'h0, ~SYNC_PATTERN);
        @(posedge aclk);
        #1;
        `CHK({exec_valid, reject_valid, trim_code}, {2'b00, 16'h0000})
        frm(1'b0, CMD_SEQ_WRITE, 5'h05, 4'h2, 24'h10aa00, 1'b1);
        frm(1'b0, CMD_SEQ_WRITE, 5'h05, 4'h1, 24'h10aa00, 1'b0);
        frm(1'b1, CMD_SEQ_WRITE, 5'h05, 4'h4, 24'h021122, 1'b1);
        frm(1'b1, CMD_SEQ_WRITE, 5'h05, 4'h2, 24'h000000, 1'b0);
        frm(1'b0, CMD_SEL_WRITE, 5'h05, 4'h3, 24'h102030, 1'b0);
        frm(1'b0, CMD_SEL_WRITE, 5'h05, 4'h4, 24'h102030, 1'b1);
        frm(1'b1, CMD_SEL_WRITE, 5'h05, 4'h5, 24'h021122, 1'b1);
        frm(1'b0, 6'h02, 5'h05, 4'h0, 24'h0, 1'b0);
        frm(1'b0, 6'h0b, 5'h05, 4'h0, 24'h0, 1'b0);
        frm(1'b0, 6'h0f, 5'h05, 4'h0, 24'h0, 1'b0);
        frm(1'b0, CMD_START, 5'h05, 4'h2, 24'h0f0f00, 1'b1);
        frm(1'b1, CMD_OFF, 5'h05, 4'h3, 24'h0f0f00, 1'b0);
        frm(1'b0, CMD_FB_REFRESH, 5'h06, 4'h1, 24'h7e0000, 1'b0);
        frm(1'b0, CMD_DUTY_A, 5'h05, 4'h8, 24'h123456, 1'b1);
        frm(1'b1, CMD_DUTY_C, 5'h05, 4'h8, 24'h123456, 1'b0);
        frm(1'b1, CMD_DUTY_PAIR, 5'h1f, 4'he, 24'habcdef, 1'b1);
        frm(1'b0, CMD_NVM_WRITE, 5'h05, 4'h4, 24'ha50102, 1'b1);
        frm(1'b0, CMD_NVM_WRITE, 5'h05, 4'h4, 24'h000102, 1'b0);
        frm(1'b0, CMD_SEQ_READ, 5'h05, 4'h1, 24'h200000, 1'b1);
        frm(1'b1, CMD_SEQ_READ, 5'h05, 4'h1, 24'h200000, 1'b0);
        frm(1'b0, CMD_SEL_READ, 5'h05, 4'h8, 24'h010203, 1'b1);
        frm(1'b1, CMD_FD_SEQ_READ, 5'h05, 4'h2, 24'h030000, 1'b1);
        frm(1'b1, CMD_FD_SEL_READ, 5'h05, 4'h3, 24'h020000, 1'b1);
        frm(1'b1, CMD_FD_SEL_READ, 5'h05, 4'h3, 24'h000000, 1'b0);
        frm(1'b0, CMD_DIAG_TRIG, 5'h05, 4'h0, 24'h0, 1'b1);
        frm(1'b0, CMD_FEEDBACK, 5'h05, 4'h0, 24'h0, 1'b0);
        frm(1'b0, CMD_BC_TRIM, 5'h11, 4'h0, 24'h0, 1'b1);
        axi_wr(REG_CTRL, 32'h000000e5, resp);
        `CHK(resp, RESP_OKAY)
        frm(1'b0, CMD_NVM_WRITE, 5'h05, 4'h4, 24'ha50102, 1'b0);
        $display("test done: frames");
        fb_enter();
        axi_rd(REG_STATUS, rd_data, resp);
        `CHK(rd_data[0], 1'b1)
        frm(1'b0, CMD_START, 5'h05, 4'h2, 24'h0f0f00, 1'b0);
        frm(1'b0, CMD_SEQ_WRITE, 5'h05, 4'h2, 24'h10aa00, 1'b0);
        frm(1'b0, CMD_FB_REFRESH, 5'h05, 4'h1, 24'h7e0000, 1'b1);
        frm(1'b0, CMD_FB_EXIT, 5'h05, 4'h3, 24'h1e2e4e, 1'b1);
        `CHK(fallback_mode, 1'b0)
        fb_enter();
        frm(1'b1, CMD_BC_EXIT, 5'h09, 4'h3, 24'h1e2e4e, 1'b1);
        `CHK(fallback_mode, 1'b0)
        $display("test done: fallback");
        final_report();
    end
endmodule
`default_nettype wire

// ===== test/host_frame_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host frame source
// ****************************************
module host_frame_model (
    input  wire logic   aclk,
    output logic        frame_valid,
    output logic        frame_ide,
    output logic        frame_fd,
    output logic [10:0] frame_std_id,
    output logic [17:0] frame_ext_id,
    output logic [3:0]  frame_len,
    output logic [119:0] frame_data,
    output logic [15:0] frame_sync_span
);
    // Idle bus at time zero
    initial begin
        frame_valid = 1'b0;
        frame_ide = 1'b0;
        frame_fd = 1'b0;
        frame_std_id = 11'h000;
        frame_ext_id = 18'h00000;
        frame_len = 4'h0;
        frame_data = '0;
        frame_sync_span = 16'h0000;
    end
    // One frame, one cycle; fields go stale after the take edge
    task automatic send(input logic fd, input logic [5:0] c, input logic [4:0] a, input logic [3:0] l,
                        input logic [23:0] b, input logic [10:0] sid);
        @(posedge aclk);
        frame_valid <= 1'b1;
        frame_ide <= 1'b1;
        frame_std_id <= sid;
        frame_ext_id <= {7'h00, c, a};
        frame_fd <= fd;
        frame_len <= l;
        frame_data <= {b, 96'h0};
        frame_sync_span <= 16'h0140 + {10'h000, c};
        @(posedge aclk);
        frame_valid <= 1'b0;
        frame_std_id <= ~sid;
        frame_ext_id <= ~{7'h00, c, a};
        frame_data <= ~{b, 96'h0};
    endtask
endmodule
`default_nettype wire
